// ### hw/serial_channel_mode_event_defines.vh
/*
 Constants for the serial channel mode and event controller: kernel behaviour codes,
 operating states, protocol codes, event bit positions and reset values.
 Assumes inclusion by bare name from the design files of this block only.
*/
// Operation
// - behaviour field 00/01 run unaffected, 10/11 stop at protocol stop condition.
// - no suspend or clock-off request means normal operation using normal field.
// - suspend request keeps clock and registers, behaviour from suspend field.
// - clock-off uses its field; clock gated only when all channels stopped.
// - clock enable 0 or clock-off stopped blocks register access except config.
// - detected event sets its flag, which stays until software clears it.
// - enabled event requests interrupt on every detection, flag state irrelevant.
// - per-event node pointer picks which service-request output fires.
// - each transfer event has own enable gating its interrupt.
// - new received word with marker 0 gives standard receive event.
// - new received word with marker 1 gives alternative receive event.
// - marker means parity, frame start or side; always 0 in synchronous mode.
// - receive start on first bit edge with reception on, via tx buffer pointer.
// - receive start latches receive shift settings; new ones may follow.
// - synchronous or I2S single shot clears tx data valid on receive start.
// - last shift edge of transmitted word raises transmit shift event.
// - first bit out with transmission on raises tx buffer event, latches, frees.
// - async or I2C single shot clears tx data valid on tx buffer event.
// - overwriting unread oldest word raises data lost, via protocol pointer.
`ifndef SERIAL_CHANNEL_MODE_EVENT_DEFINES_VH
`define SERIAL_CHANNEL_MODE_EVENT_DEFINES_VH

`define KB_RUN0 2'h0
`define KB_RUN1 2'h1
`define KB_STOP0 2'h2
`define KB_STOP1 2'h3
`define KB_STOP_BIT 1

`define ST_NORMAL 2'h0
`define ST_SUSPEND 2'h1
`define ST_CLKOFF 2'h2
`define ST_CLKSTOP 2'h3

`define PM_ASYNC 2'h0
`define PM_SYNC 2'h1
`define PM_I2C 2'h2
`define PM_I2S 2'h3

`define EV_COUNT 6
`define EV_RECEIVE 0
`define EV_RX_START 1
`define EV_ALT_RECEIVE 2
`define EV_TX_SHIFT 3
`define EV_TX_BUFFER 4
`define EV_DATA_LOST 5

`define SR_COUNT 6
`define NODE_W 3
`define SET_W 8
`define RXQ_FULL 2'h2

`define FLAGS_RESET 6'h00
`define SETTINGS_RESET 8'h00

`endif

// ### hw/event_flag_router.v
/*
 Sticky event flags and service-request routing for the six data transfer events.
 Assumes one-cycle event pulses on mclk and a one-cycle clear strobe with its mask.
*/
`timescale 1ns/1ps
`include "serial_channel_mode_event_defines.vh"

module event_flag_router (
    input wire mclk,
    input wire rst_n,
    input wire [5:0] event_pulse,
    input wire [5:0] irq_enable,
    input wire [2:0] receive_node_select,
    input wire [2:0] tx_buffer_node_select,
    input wire [2:0] alt_receive_node_select,
    input wire [2:0] tx_shift_node_select,
    input wire [2:0] protocol_node_select,
    input wire clear_strobe,
    input wire [5:0] clear_bits,
    output reg [5:0] flags,
    output reg [5:0] service_request_out
);

    // one-hot of the selected output; pointer codes past the last output route nowhere
    function [5:0] route;
        input [2:0] sel;
        begin
            route = (sel < `SR_COUNT) ? (6'h01 << sel) : 6'h00;
        end
    endfunction

    wire [5:0] hit;
    wire [5:0] clear_mask;
    reg [5:0] next_sr;

    // flag state is not consulted, so every enabled detection requests again
    assign hit = event_pulse & irq_enable;
    assign clear_mask = clear_strobe ? clear_bits : 6'h00;

    always @* begin
        next_sr = 6'h00;
        // or-ing collapses coincident events on one output into a single pulse
        if (hit[`EV_RECEIVE]) next_sr = next_sr | route(receive_node_select);
        if (hit[`EV_RX_START]) next_sr = next_sr | route(tx_buffer_node_select);
        if (hit[`EV_ALT_RECEIVE]) next_sr = next_sr | route(alt_receive_node_select);
        if (hit[`EV_TX_SHIFT]) next_sr = next_sr | route(tx_shift_node_select);
        if (hit[`EV_TX_BUFFER]) next_sr = next_sr | route(tx_buffer_node_select);
        if (hit[`EV_DATA_LOST]) next_sr = next_sr | route(protocol_node_select);
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= `FLAGS_RESET;
            service_request_out <= 6'h00;
        end else begin
            // set beats clear so an event in the clearing cycle is kept
            flags <= (flags & ~clear_mask) | event_pulse;
            service_request_out <= next_sr;
        end
    end

endmodule

// ### hw/serial_channel_mode_event_ctrl.v
/*
 Kernel mode control and data transfer event logic of one serial channel.
 Assumes suspend and clock-off requests arrive asynchronously from the system
 control unit; all other inputs come from logic on mclk, event inputs as pulses.
*/
`timescale 1ns/1ps
`include "serial_channel_mode_event_defines.vh"

module serial_channel_mode_event_ctrl (
    input wire mclk,
    input wire rst_n,
    input wire suspend_req,
    input wire clockoff_req,
    input wire module_clock_enable,
    input wire [1:0] normal_mode_behavior,
    input wire [1:0] suspend_mode_behavior,
    input wire [1:0] clockoff_mode_behavior,
    input wire protocol_stop_reached,
    input wire other_channels_stopped,
    input wire [1:0] protocol_mode,
    input wire single_shot,
    input wire reception_enable,
    input wire transmission_enable,
    input wire rx_word_valid,
    input wire protocol_receive_marker,
    input wire rx_buffer_read,
    input wire rx_first_bit,
    input wire tx_first_bit,
    input wire tx_last_edge,
    input wire tx_data_write,
    input wire [7:0] rx_shift_settings_next,
    input wire [7:0] tx_shift_settings_next,
    input wire [5:0] irq_enable,
    input wire [2:0] receive_node_select,
    input wire [2:0] tx_buffer_node_select,
    input wire [2:0] alt_receive_node_select,
    input wire [2:0] tx_shift_node_select,
    input wire [2:0] protocol_node_select,
    input wire status_clear_write,
    input wire [5:0] protocol_status_clear,
    output reg [1:0] operating_state,
    output reg [1:0] kernel_mode,
    output reg channel_stop_req,
    output reg reg_access_allowed,
    output reg module_clock_gate_req,
    output reg tx_data_valid,
    output reg tx_buffer_free,
    output reg [7:0] rx_shift_settings,
    output reg [7:0] tx_shift_settings,
    output reg [1:0] rx_words_pending,
    output wire [5:0] protocol_status,
    output wire [5:0] service_request_out
);

    // request synchronisers: first stage is read only by the second
    reg suspend_meta;
    reg suspend_sync;
    reg clockoff_meta;
    reg clockoff_sync;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            suspend_meta <= 1'b0;
            suspend_sync <= 1'b0;
        end else begin
            suspend_meta <= suspend_req;
            suspend_sync <= suspend_meta;
        end
    end

    // the requests settle independently, so the state logic accepts either order
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clockoff_meta <= 1'b0;
            clockoff_sync <= 1'b0;
        end else begin
            clockoff_meta <= clockoff_req;
            clockoff_sync <= clockoff_meta;
        end
    end

    // true for the stop codes 10 and 11; run codes 00 and 01 leave the channel alone
    function is_stop;
        input [1:0] behavior;
        begin
            is_stop = behavior[`KB_STOP_BIT];
        end
    endfunction

    // leaving clock-off drops back to whichever request is still pending
    function [1:0] resume_state;
        input suspend_pending;
        begin
            if (suspend_pending) begin
                resume_state = `ST_SUSPEND;
            end else begin
                resume_state = `ST_NORMAL;
            end
        end
    endfunction

    // clocked protocols end a single-shot word at the receive start
    function ends_on_rx_start;
        input [1:0] mode;
        begin
            ends_on_rx_start = (mode == `PM_SYNC) || (mode == `PM_I2S);
        end
    endfunction

    // framed protocols end a single-shot word at the transmit buffer event
    function ends_on_tx_buffer;
        input [1:0] mode;
        begin
            ends_on_tx_buffer = (mode == `PM_ASYNC) || (mode == `PM_I2C);
        end
    endfunction

    // the store holds two words; a third arrival before a read overwrites
    function store_full;
        input [1:0] count;
        begin
            store_full = (count == `RXQ_FULL);
        end
    endfunction

    reg [1:0] next_state;
    reg [1:0] next_mode;

    // clock-off outranks suspend: power saving wins when both are pending
    always @* begin
        next_state = operating_state;
        case (operating_state)
            `ST_NORMAL: begin
                if (clockoff_sync) begin
                    next_state = `ST_CLKOFF;
                end else if (suspend_sync) begin
                    next_state = `ST_SUSPEND;
                end
            end
            `ST_SUSPEND: begin
                if (clockoff_sync) begin
                    next_state = `ST_CLKOFF;
                end else if (!suspend_sync) begin
                    next_state = `ST_NORMAL;
                end
            end
            `ST_CLKOFF: begin
                if (!clockoff_sync) begin
                    next_state = resume_state(suspend_sync);
                end else if (is_stop(clockoff_mode_behavior) && protocol_stop_reached) begin
                    next_state = `ST_CLKSTOP;
                end
            end
            `ST_CLKSTOP: begin
                if (!clockoff_sync) begin
                    next_state = resume_state(suspend_sync);
                end
            end
            default: begin
                next_state = `ST_NORMAL;
            end
        endcase
    end

    always @* begin
        case (next_state)
            `ST_NORMAL: next_mode = normal_mode_behavior;
            `ST_SUSPEND: next_mode = suspend_mode_behavior;
            `ST_CLKOFF: next_mode = clockoff_mode_behavior;
            `ST_CLKSTOP: next_mode = clockoff_mode_behavior;
            default: next_mode = normal_mode_behavior;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            operating_state <= `ST_NORMAL;
            kernel_mode <= `KB_RUN0;
            channel_stop_req <= 1'b0;
            reg_access_allowed <= 1'b0;
            module_clock_gate_req <= 1'b0;
        end else begin
            operating_state <= next_state;
            kernel_mode <= next_mode;
            channel_stop_req <= is_stop(next_mode);
            // only the kernel configuration stays reachable outside this window
            reg_access_allowed <= module_clock_enable && (next_state != `ST_CLKSTOP);
            // the shared module clock may only stop once every channel has stopped
            module_clock_gate_req <= (next_state == `ST_CLKSTOP) && other_channels_stopped;
        end
    end

    // events are ignored while the kernel clock is off or gated
    wire kernel_live;
    wire marker_eff;
    wire rx_event;
    wire alt_event;
    wire rx_start_event;
    wire tx_shift_event;
    wire tx_buffer_event;
    wire data_lost_event;
    wire clear_tdv;
    wire clear_strobe;
    wire [5:0] event_pulse;

    assign kernel_live = module_clock_enable && (operating_state != `ST_CLKSTOP);

    // marker is meaningless in synchronous mode, so it is forced low there
    assign marker_eff = (protocol_mode == `PM_SYNC) ? 1'b0 : protocol_receive_marker;

    assign rx_event = kernel_live && rx_word_valid && !marker_eff;
    assign alt_event = kernel_live && rx_word_valid && marker_eff;
    assign rx_start_event = kernel_live && rx_first_bit && reception_enable;
    assign tx_shift_event = kernel_live && tx_last_edge;
    assign tx_buffer_event = kernel_live && tx_first_bit && transmission_enable;

    // two-word receive store: a third word before a read loses the oldest
    assign data_lost_event = kernel_live && rx_word_valid && !rx_buffer_read
        && store_full(rx_words_pending);

    reg [1:0] next_rx_pending;

    // a word arriving in the cycle of a read leaves the count unchanged
    always @* begin
        next_rx_pending = rx_words_pending;
        if (kernel_live) begin
            if (rx_word_valid && !rx_buffer_read) begin
                if (!store_full(rx_words_pending)) begin
                    next_rx_pending = rx_words_pending + 2'h1;
                end
            end else if (!rx_word_valid && rx_buffer_read) begin
                if (rx_words_pending != 2'h0) begin
                    next_rx_pending = rx_words_pending - 2'h1;
                end
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_words_pending <= 2'h0;
        end else begin
            rx_words_pending <= next_rx_pending;
        end
    end

    // which event ends a single-shot word depends on the protocol
    assign clear_tdv = single_shot
        && ((ends_on_rx_start(protocol_mode) && rx_start_event)
        || (ends_on_tx_buffer(protocol_mode) && tx_buffer_event));

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_valid <= 1'b0;
        end else if (tx_data_write) begin
            // a new buffer write in the same cycle keeps the flag set
            tx_data_valid <= 1'b1;
        end else if (clear_tdv) begin
            tx_data_valid <= 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer_free <= 1'b0;
        end else begin
            tx_buffer_free <= tx_buffer_event;
        end
    end

    // settings freeze at the word start; later writes apply to the next word
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift_settings <= `SETTINGS_RESET;
        end else if (rx_start_event) begin
            rx_shift_settings <= rx_shift_settings_next;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_settings <= `SETTINGS_RESET;
        end else if (tx_buffer_event) begin
            tx_shift_settings <= tx_shift_settings_next;
        end
    end

    // a clear written while registers are unreachable is dropped
    assign clear_strobe = status_clear_write && reg_access_allowed;

    assign event_pulse = {data_lost_event, tx_buffer_event, tx_shift_event,
        alt_event, rx_start_event, rx_event};

    event_flag_router u_router (
        .mclk(mclk),
        .rst_n(rst_n),
        .event_pulse(event_pulse),
        .irq_enable(irq_enable),
        .receive_node_select(receive_node_select),
        .tx_buffer_node_select(tx_buffer_node_select),
        .alt_receive_node_select(alt_receive_node_select),
        .tx_shift_node_select(tx_shift_node_select),
        .protocol_node_select(protocol_node_select),
        .clear_strobe(clear_strobe),
        .clear_bits(protocol_status_clear),
        .flags(protocol_status),
        .service_request_out(service_request_out)
    );

endmodule

// ### dv/sys_state_model.sv
/*
 System state control model: turns a commanded device mode into request levels.
 Assumes the bench changes mode_cmd just after a rising clock edge.
*/
`timescale 1ns/1ps
module sys_state_model (
    input wire mclk,
    input wire rst_n,
    input wire [1:0] mode_cmd,
    output reg suspend_req,
    output reg clockoff_req
);
    // both bits set asks for suspend and clock-off together
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            suspend_req <= 1'b0;
            clockoff_req <= 1'b0;
        end else begin
            suspend_req <= mode_cmd[0];
            clockoff_req <= mode_cmd[1];
        end
    end
endmodule

// ### dv/serial_channel_mode_event_ctrl_properties.sv
/*
 Concurrent checks on the mode and event controller ports.
 Assumes one clock domain, mclk, with rst_n as its asynchronous reset.
*/
`timescale 1ns/1ps
module serial_channel_mode_event_ctrl_properties (
    input wire mclk,
    input wire rst_n,
    input wire module_clock_enable,
    input wire [1:0] suspend_mode_behavior,
    input wire [1:0] protocol_mode,
    input wire rx_word_valid,
    input wire protocol_receive_marker,
    input wire rx_first_bit,
    input wire tx_first_bit,
    input wire tx_last_edge,
    input wire [5:0] irq_enable,
    input wire [2:0] receive_node_select,
    input wire status_clear_write,
    input wire [5:0] protocol_status_clear,
    input wire [1:0] operating_state,
    input wire [1:0] kernel_mode,
    input wire reg_access_allowed,
    input wire module_clock_gate_req,
    input wire [5:0] protocol_status,
    input wire [5:0] service_request_out
);
    wire live = module_clock_enable && operating_state != 2'h3;
    wire quiet = !(rx_word_valid || rx_first_bit || tx_first_bit || tx_last_edge);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    chk_flag_sticky: assert property (
        !status_clear_write |=> (protocol_status & $past(protocol_status)) == $past(protocol_status))
        else $error("event flag dropped without a clear");
    chk_rx_flag: assert property (
        live && rx_word_valid && (!protocol_receive_marker || protocol_mode == 2'h1)
        |=> protocol_status[0]) else $error("receive flag not set");
    chk_alt_flag: assert property (
        live && rx_word_valid && protocol_receive_marker && protocol_mode != 2'h1
        |=> protocol_status[2]) else $error("alternative receive flag not set");
    chk_rx_route: assert property (
        live && rx_word_valid && !protocol_receive_marker && irq_enable[0]
        && receive_node_select < 3'h6 |=> service_request_out[$past(receive_node_select)])
        else $error("receive request missing on selected output");
    chk_no_irq: assert property (
        irq_enable == 6'h00 |=> service_request_out == 6'h00)
        else $error("request raised with all enables off");
    chk_clear_mask: assert property (
        status_clear_write && reg_access_allowed && quiet
        |=> (protocol_status & $past(protocol_status_clear)) == 6'h00)
        else $error("flag survived its clear");
    chk_gate_stop: assert property (
        module_clock_gate_req |-> operating_state == 2'h3 || $past(operating_state) == 2'h3)
        else $error("clock gate requested before stop");
    chk_access_off: assert property (
        !module_clock_enable |=> !reg_access_allowed)
        else $error("registers reachable with clock disabled");
    chk_suspend_kernel: assert property (
        operating_state == 2'h1 && $past(operating_state) == 2'h1 && $past(rst_n)
        && $stable(suspend_mode_behavior) |-> kernel_mode == suspend_mode_behavior)
        else $error("suspend behaviour not in force");
    cover property (service_request_out != 6'h00);
    cover property (operating_state == 2'h3);
    cover property (module_clock_gate_req);
endmodule
bind serial_channel_mode_event_ctrl serial_channel_mode_event_ctrl_properties i_props (.*);

// ### dv/test_serial_channel_mode_event_ctrl.sv
/*
 Bench for the channel mode and event controller: a table of single events, then
 hand-written repeat, overlap, data lost, valid flag and mode cases.
 Assumes the design and the system state model are compiled first.
*/
`timescale 1ns/1ps
module test_serial_channel_mode_event_ctrl;
    logic mclk, rst_n, suspend_req, clockoff_req, module_clock_enable;
    logic [1:0] mode_cmd, normal_mode_behavior, suspend_mode_behavior, clockoff_mode_behavior;
    logic [1:0] protocol_mode, operating_state, kernel_mode, rx_words_pending;
    logic protocol_stop_reached, other_channels_stopped, single_shot, reception_enable;
    logic transmission_enable, rx_word_valid, protocol_receive_marker, rx_buffer_read;
    logic rx_first_bit, tx_first_bit, tx_last_edge, tx_data_write, status_clear_write;
    logic channel_stop_req, reg_access_allowed, module_clock_gate_req;
    logic tx_data_valid, tx_buffer_free;
    logic [7:0] rx_shift_settings_next, tx_shift_settings_next;
    logic [7:0] rx_shift_settings, tx_shift_settings;
    logic [5:0] irq_enable, protocol_status_clear, protocol_status, service_request_out;
    logic [2:0] receive_node_select, tx_buffer_node_select, alt_receive_node_select;
    logic [2:0] tx_shift_node_select, protocol_node_select;
    int failures = 0;
    int tests_run = 0;
    // event bits, marker, protocol, enables, expected flags, expected requests
    logic [24:0] rows [7] = '{25'h103F041, 25'h113F104, 25'h117F041, 25'h083F082,
        25'h043F402, 25'h023F208, 25'h1000040};

    serial_channel_mode_event_ctrl i_serial_channel_mode_event_ctrl (.*);
    sys_state_model i_sys_state_model (.*);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task pulse(input logic [3:0] ev);
        {rx_word_valid, rx_first_bit, tx_first_bit, tx_last_edge} = ev;
        step(1);
        {rx_word_valid, rx_first_bit, tx_first_bit, tx_last_edge} = 4'h0;
    endtask
    task clear_all;
        status_clear_write = 1'b1;
        protocol_status_clear = 6'h3F;
        step(1);
        status_clear_write = 1'b0;
    endtask
    // a state that never arrives counts as a mismatch and ends the run
    task wait_state(input logic [1:0] s);
        for (int n = 0; n < 10 && operating_state !== s; n++) step(1);
        check(operating_state, s);
        if (operating_state !== s) summarize;
    endtask
    initial begin
        {rst_n, mode_cmd, protocol_stop_reached, other_channels_stopped, single_shot} = '0;
        {rx_word_valid, rx_first_bit, tx_first_bit, tx_last_edge, tx_data_write} = '0;
        {rx_buffer_read, status_clear_write, protocol_status_clear, protocol_mode} = '0;
        normal_mode_behavior = 2'h0;
        {suspend_mode_behavior, clockoff_mode_behavior} = 4'h6;
        {module_clock_enable, reception_enable, transmission_enable} = 3'h7;
        {receive_node_select, tx_buffer_node_select, alt_receive_node_select} = 9'h00A;
        {tx_shift_node_select, protocol_node_select} = 6'h1C;
        {irq_enable, protocol_receive_marker} = 7'h7E;
        {rx_shift_settings_next, tx_shift_settings_next} = 16'h5AC3;
        step(4);
        check(protocol_status, 6'h00);
        check(reg_access_allowed, 1'b0);
        rst_n = 1'b1;
        step(1);
        check(reg_access_allowed, 1'b1);
        // a read beside every arrival keeps the two-word store from overflowing
        rx_buffer_read = 1'b1;
        foreach (rows[i]) begin
            {protocol_receive_marker, protocol_mode, irq_enable} = rows[i][20:12];
            pulse(rows[i][24:21]);
            check(protocol_status, rows[i][11:6]);
            check(service_request_out, rows[i][5:0]);
            clear_all;
            check(protocol_status, 6'h00);
        end
        irq_enable = 6'h3F;
        rx_word_valid = 1'b1;
        step(1);
        check(service_request_out, 6'h01);
        step(1);
        rx_word_valid = 1'b0;
        check(service_request_out, 6'h01);
        step(3);
        check(service_request_out, 6'h00);
        check(protocol_status, 6'h01);
        status_clear_write = 1'b1;
        protocol_status_clear = 6'h3E;
        step(1);
        check(protocol_status, 6'h01);
        protocol_status_clear = 6'h01;
        step(1);
        status_clear_write = 1'b0;
        check(protocol_status, 6'h00);
        {receive_node_select, tx_buffer_node_select} = 6'h2D;
        pulse(4'hC);
        check(service_request_out, 6'h20);
        {receive_node_select, tx_buffer_node_select} = 6'h01;
        rx_buffer_read = 1'b1;
        step(2);
        rx_buffer_read = 1'b0;
        clear_all;
        irq_enable = 6'h20;
        rx_word_valid = 1'b1;
        step(2);
        check(protocol_status, 6'h01);
        step(1);
        rx_word_valid = 1'b0;
        check(protocol_status, 6'h21);
        check(service_request_out, 6'h10);
        check(rx_words_pending, 2'h2);
        rx_buffer_read = 1'b1;
        step(1);
        rx_buffer_read = 1'b0;
        check(rx_words_pending, 2'h1);
        irq_enable = 6'h3F;
        single_shot = 1'b1;
        for (int m = 0; m < 4; m++) begin
            protocol_mode = m[1:0];
            rx_shift_settings_next = 8'h50 | m[7:0];
            tx_shift_settings_next = 8'hA0 | m[7:0];
            tx_data_write = 1'b1;
            step(1);
            tx_data_write = 1'b0;
            pulse(4'h4);
            check(tx_data_valid, m[0] ? 1'b0 : 1'b1);
            check(rx_shift_settings, 8'h50 | m[7:0]);
            step(1);
            pulse(4'h2);
            check(tx_data_valid, 1'b0);
            check(tx_buffer_free, 1'b1);
            check(tx_shift_settings, 8'hA0 | m[7:0]);
        end
        {single_shot, protocol_mode} = 3'h0;
        clear_all;
        mode_cmd = 2'h1;
        wait_state(2'h1);
        step(1);
        check(kernel_mode, 2'h1);
        check(reg_access_allowed, 1'b1);
        mode_cmd = 2'h3;
        wait_state(2'h2);
        step(1);
        check(kernel_mode, 2'h2);
        check(channel_stop_req, 1'b1);
        check(reg_access_allowed, 1'b1);
        protocol_stop_reached = 1'b1;
        wait_state(2'h3);
        step(1);
        check(reg_access_allowed, 1'b0);
        check(module_clock_gate_req, 1'b0);
        other_channels_stopped = 1'b1;
        step(2);
        check(module_clock_gate_req, 1'b1);
        pulse(4'h8);
        check(protocol_status, 6'h00);
        {mode_cmd, protocol_stop_reached, other_channels_stopped} = 4'h0;
        wait_state(2'h0);
        step(1);
        check(kernel_mode, 2'h0);
        check(channel_stop_req, 1'b0);
        check(reg_access_allowed, 1'b1);
        module_clock_enable = 1'b0;
        step(2);
        check(reg_access_allowed, 1'b0);
        summarize;
    end
endmodule
